// File: design/erase_seq_cfg.svh
// constants for the whole-array erase sequencer (host side)
// assumes a 20 MHz i_mclk; bus timing counts are whole clock cycles
`ifndef ERASE_SEQ_CFG_SVH
`define ERASE_SEQ_CFG_SVH

`define CMD_SETUP_ERASE     8'h20
`define CMD_ERASE           8'h20
`define CMD_ERASE_VERIFY    8'hA0
`define CMD_READ            8'h00
`define DATA_ERASED         8'hFF
`define DATA_PROGRAMMED     8'h00
`define CLK_MHZ             20
`define ERASE_PULSE_TIME_MS 10
`define ERASE_PULSE_CYCLES  (`ERASE_PULSE_TIME_MS * 1000 * `CLK_MHZ)
`define VERIFY_RECOVERY_NS  6000
`define VERIFY_RECOVERY_CYC ((`VERIFY_RECOVERY_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_LOW_CYCLES   4
`define READ_ACCESS_CYCLES  4
`define MAX_PULSES_DEFAULT  1000

`endif

// File: design/erase_seq_host.sv
// host controller that drives a byte-wide flash through a full chip erase
// assumes flash pins are sampled synchronous to i_mclk; the supply switch is external
`timescale 1ns/1ns
`include "erase_seq_cfg.svh"
module erase_seq_host #(
    parameter int AW          = 17,
    parameter int PULSE_CYC   = `ERASE_PULSE_CYCLES,
    parameter int MAX_PULSES  = `MAX_PULSES_DEFAULT,
    parameter bit FINAL_CHECK = 1'b1
) (
    // clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_reset,
    // user control
    input  wire logic                       i_start,
    input  wire logic                       i_program_supply_high,
    output erase_seq_pkg::status_t          o_status,
    output logic [15:0]                     o_pulse_count,
    output logic [AW-1:0]                   o_fail_addr,
    output logic                            o_supply_request,
    // flash pins
    output logic [AW-1:0]                   o_addr,
    output erase_seq_pkg::flash_pins_t      o_pins,
    input  wire logic [7:0]                 i_dq
);

    typedef struct packed {
        erase_seq_pkg::state_t      st;
        logic [31:0]                cnt;
        logic [AW-1:0]              addr;
        logic [15:0]                pulses;
        logic                       supply;
        logic                       pre_ok;
        erase_seq_pkg::flash_pins_t pins;
        erase_seq_pkg::status_t     stat;
    } host_state_t;

    localparam logic [AW-1:0] LAST_ADDR = {AW{1'b1}};

    // released bus: nothing selected, data not driven
    localparam erase_seq_pkg::flash_pins_t PINS_IDLE = '{
        ce_n:   1'b1,
        oe_n:   1'b1,
        we_n:   1'b1,
        dq_oe:  1'b0,
        dq_out: 8'h00
    };

    localparam erase_seq_pkg::status_t STAT_CLEAR = '{
        busy:        1'b0,
        done:        1'b0,
        fail:        1'b0,
        compare_err: 1'b0
    };

    host_state_t s_r;
    host_state_t s_nxt;
    logic        byte_erased;
    logic        byte_programmed;

    // one write cycle: strobe low for a few cycles with data driven, then release
    function automatic logic write_step(input logic [31:0] c);
        write_step = (c >= 32'(`STROBE_LOW_CYCLES));
    endfunction : write_step

    // a read holds select and output enable low until the data has settled
    function automatic logic read_last(input logic [31:0] c);
        read_last = (c == 32'(`READ_ACCESS_CYCLES));
    endfunction : read_last

    assign byte_erased     = (i_dq == `DATA_ERASED);
    assign byte_programmed = (i_dq == `DATA_PROGRAMMED);

    always_comb begin
        s_nxt = s_r;
        s_nxt.cnt = s_r.cnt + 32'h1;
        case (s_r.st)
            erase_seq_pkg::ST_IDLE: begin
                s_nxt.pins = PINS_IDLE;
                if (i_start) begin
                    s_nxt.stat = STAT_CLEAR;
                    s_nxt.stat.busy = 1'b1;
                    s_nxt.addr = '0;
                    s_nxt.pulses = 16'h0;
                    s_nxt.supply = 1'b1;
                    s_nxt.pre_ok = 1'b0;
                    s_nxt.cnt = 32'h0;
                    s_nxt.st = erase_seq_pkg::ST_PRECHECK;
                end
            end
            erase_seq_pkg::ST_PRECHECK: begin
                if (s_r.pre_ok) begin
                    // wait for the programming supply before any erase write
                    s_nxt.cnt = 32'h0;
                    if (i_program_supply_high) begin
                        s_nxt.st = erase_seq_pkg::ST_WR_SETUP;
                    end
                end else begin
                    // read pass: erasing is refused unless every byte is preprogrammed
                    s_nxt.pins.ce_n = 1'b0;
                    s_nxt.pins.oe_n = 1'b0;
                    s_nxt.pins.we_n = 1'b1;
                    s_nxt.pins.dq_oe = 1'b0;
                    if (read_last(s_r.cnt)) begin
                        s_nxt.pins = PINS_IDLE;
                        s_nxt.cnt = 32'h0;
                        if (!byte_programmed) begin
                            s_nxt.stat.fail = 1'b1;
                            s_nxt.st = erase_seq_pkg::ST_DONE;
                        end else if (s_r.addr == LAST_ADDR) begin
                            s_nxt.addr = '0;
                            s_nxt.pre_ok = 1'b1;
                        end else begin
                            s_nxt.addr = s_r.addr + 1'b1;
                        end
                    end
                end
            end
            erase_seq_pkg::ST_WR_SETUP,
            erase_seq_pkg::ST_WR_ERASE,
            erase_seq_pkg::ST_WR_VERIFY,
            erase_seq_pkg::ST_WR_READ: begin
                s_nxt.pins.ce_n = 1'b0;
                s_nxt.pins.oe_n = 1'b1;
                s_nxt.pins.dq_oe = 1'b1;
                case (s_r.st)
                    erase_seq_pkg::ST_WR_SETUP:  s_nxt.pins.dq_out = `CMD_SETUP_ERASE;
                    erase_seq_pkg::ST_WR_ERASE:  s_nxt.pins.dq_out = `CMD_ERASE;
                    erase_seq_pkg::ST_WR_VERIFY: s_nxt.pins.dq_out = `CMD_ERASE_VERIFY;
                    default:                     s_nxt.pins.dq_out = `CMD_READ;
                endcase
                s_nxt.pins.we_n = write_step(s_r.cnt);
                if (s_r.cnt == 32'(`STROBE_LOW_CYCLES + 1)) begin
                    s_nxt.pins = PINS_IDLE;
                    s_nxt.cnt = 32'h0;
                    case (s_r.st)
                        erase_seq_pkg::ST_WR_SETUP: s_nxt.st = erase_seq_pkg::ST_WR_ERASE;
                        erase_seq_pkg::ST_WR_ERASE: begin
                            s_nxt.pulses = s_r.pulses + 16'h1;
                            s_nxt.st = erase_seq_pkg::ST_PULSE;
                        end
                        erase_seq_pkg::ST_WR_VERIFY: s_nxt.st = erase_seq_pkg::ST_RECOVER;
                        default: s_nxt.st = FINAL_CHECK ? erase_seq_pkg::ST_FINAL_RD
                                                        : erase_seq_pkg::ST_DONE;
                    endcase
                end
            end
            erase_seq_pkg::ST_PULSE: begin
                // bus stays idle for the full erase pulse
                if (s_r.cnt >= 32'(PULSE_CYC - 1)) begin
                    s_nxt.cnt = 32'h0;
                    s_nxt.st = erase_seq_pkg::ST_WR_VERIFY;
                end
            end
            erase_seq_pkg::ST_RECOVER: begin
                if (s_r.cnt >= 32'(`VERIFY_RECOVERY_CYC - 1)) begin
                    s_nxt.cnt = 32'h0;
                    s_nxt.st = erase_seq_pkg::ST_RD_VERIFY;
                end
            end
            erase_seq_pkg::ST_RD_VERIFY,
            erase_seq_pkg::ST_FINAL_RD: begin
                s_nxt.pins.ce_n = 1'b0;
                s_nxt.pins.oe_n = 1'b0;
                s_nxt.pins.we_n = 1'b1;
                s_nxt.pins.dq_oe = 1'b0;
                if (read_last(s_r.cnt)) begin
                    s_nxt.pins.ce_n = 1'b1;
                    s_nxt.pins.oe_n = 1'b1;
                    s_nxt.cnt = 32'h0;
                    if (s_r.st == erase_seq_pkg::ST_FINAL_RD) begin
                        // optional read-mode compare from the current address (0 after a pass, the failing byte after a fail) to the last byte
                        if (!byte_erased) begin
                            s_nxt.stat.compare_err = 1'b1;
                            s_nxt.st = erase_seq_pkg::ST_DONE;
                        end else if (s_r.addr == LAST_ADDR) begin
                            s_nxt.st = erase_seq_pkg::ST_DONE;
                        end else begin
                            s_nxt.addr = s_r.addr + 1'b1;
                        end
                    end else if (byte_erased) begin
                        if (s_r.addr == LAST_ADDR) begin
                            s_nxt.addr = '0;
                            s_nxt.st = erase_seq_pkg::ST_WR_READ;
                        end else begin
                            s_nxt.addr = s_r.addr + 1'b1;
                            s_nxt.st = erase_seq_pkg::ST_WR_VERIFY;
                        end
                    end else if (s_r.pulses >= 16'(MAX_PULSES)) begin
                        s_nxt.stat.fail = 1'b1;
                        s_nxt.st = erase_seq_pkg::ST_WR_READ;
                    end else begin
                        // address kept so verify resumes at the failing byte
                        s_nxt.st = erase_seq_pkg::ST_WR_SETUP;
                    end
                end
            end
            erase_seq_pkg::ST_DONE: begin
                s_nxt.supply = 1'b0;
                s_nxt.stat.busy = 1'b0;
                s_nxt.stat.done = 1'b1;
                s_nxt.st = erase_seq_pkg::ST_IDLE;
            end
            default: s_nxt.st = erase_seq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '{st:     erase_seq_pkg::ST_IDLE,
                     cnt:    32'h0,
                     addr:   '0,
                     pulses: 16'h0,
                     supply: 1'b0,
                     pre_ok: 1'b0,
                     pins:   PINS_IDLE,
                     stat:   STAT_CLEAR};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_status         = s_r.stat;
    assign o_pulse_count    = s_r.pulses;
    assign o_fail_addr      = s_r.addr;
    assign o_supply_request = s_r.supply;
    assign o_addr           = s_r.addr;
    assign o_pins           = s_r.pins;

endmodule : erase_seq_host

// File: design/erase_seq_pkg.sv
// types for the whole-array erase sequencer
// assumes the constants header is included by the module
package erase_seq_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_PRECHECK,
        ST_WR_SETUP,
        ST_WR_ERASE,
        ST_PULSE,
        ST_WR_VERIFY,
        ST_RECOVER,
        ST_RD_VERIFY,
        ST_WR_READ,
        ST_FINAL_RD,
        ST_DONE
    } state_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        dq_oe;
        logic [7:0]  dq_out;
    } flash_pins_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic fail;
        logic compare_err;
    } status_t;

endpackage : erase_seq_pkg

// File: verif/erase_seq_host_asserts.sv
// checker for the erase sequencer's flash pin timing
// assumes a bind onto erase_seq_host; single clock domain
`timescale 1ns/1ns
module erase_seq_host_asserts #(
    parameter int AW        = 17,
    parameter int PULSE_CYC = 50
) (
    input wire logic                  i_mclk,
    input wire logic                  i_reset,
    input wire logic                  i_program_supply_high,
    input erase_seq_pkg::status_t     o_status,
    input erase_seq_pkg::flash_pins_t o_pins
);
    logic [15:0] idle_r;
    logic [15:0] since_r;
    logic [15:0] hist_r;
    // idle run of the select, time since last write, last two commands
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            idle_r  <= 16'h0000;
            since_r <= 16'h0000;
            hist_r  <= 16'h0000;
        end else begin
            idle_r  <= o_pins.ce_n ? idle_r + 16'h0001 : 16'h0000;
            since_r <= $rose(o_pins.we_n) ? 16'h0000 : since_r + 16'h0001;
            hist_r  <= $rose(o_pins.we_n) ? {hist_r[7:0], o_pins.dq_out} : hist_r;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_we_pulse;
        !o_pins.we_n [*4] ##1 o_pins.we_n;
    endsequence
    sequence s_rd_cycle;
        !o_pins.oe_n [*4] ##1 o_pins.oe_n;
    endsequence
    a_we_with_ce:
        assert property (!o_pins.we_n |-> !o_pins.ce_n) else $error("strobe without select");
    a_we_width:
        assert property ($fell(o_pins.we_n) |-> s_we_pulse) else $error("strobe width wrong");
    a_hold_data:
        assert property ($rose(o_pins.we_n) |-> o_pins.dq_oe && $stable(o_pins.dq_out))
            else $error("data moved at strobe end");
    a_cmd_code:
        assert property ($rose(o_pins.we_n) |-> o_pins.dq_out inside {8'h20, 8'hA0, 8'h00})
            else $error("unknown command code");
    a_no_contend:
        assert property (!o_pins.oe_n |-> !o_pins.dq_oe) else $error("bus contention");
    a_read_len:
        assert property ($fell(o_pins.oe_n) |-> s_rd_cycle) else $error("read length wrong");
    a_verify_wait:
        assert property ($fell(o_pins.oe_n) && hist_r[7:0] == 8'hA0 |-> since_r >= 16'h0078)
            else $error("verify read too early");
    a_pulse_idle:
        assert property ($fell(o_pins.ce_n) && hist_r == 16'h2020 |-> idle_r >= PULSE_CYC - 1)
            else $error("erase pulse cut short");
    a_supply_gate:
        assert property ($fell(o_pins.we_n) |-> i_program_supply_high) else $error("write, no supply");
    a_idle_quiet:
        assert property (!o_status.busy |-> o_pins.ce_n) else $error("selected while idle");
endmodule : erase_seq_host_asserts

// File: verif/flash_model.sv
// flash device model: command state, erase level, margin reads
// assumes host pins registered on i_mclk; dq has no pull, idle shows churn
`timescale 1ns/1ns
module flash_model (
    // host side
    input wire logic                  i_mclk,
    input wire logic                  i_reset,
    input wire logic [2:0]            i_addr,
    input erase_seq_pkg::flash_pins_t i_pins,
    input wire logic                  i_supply_high,
    // one byte that needs more pulses
    input wire logic [2:0]            i_weak_addr,
    input wire logic [3:0]            i_weak_need,
    // data and command state
    output logic [7:0]                o_dq,
    output logic [1:0]                o_mode
);
    logic [3:0] lvl_r;
    logic [2:0] vaddr_r;
    logic       we_q;
    logic [7:0] last_r;
    logic [2:0] ra;
    logic [3:0] need;
    assign ra   = (o_mode == 2'h3) ? vaddr_r : i_addr;
    assign need = (ra == i_weak_addr) ? i_weak_need : 4'h1;
    assign o_dq = (!i_pins.ce_n && !i_pins.oe_n)
                ? ((lvl_r >= need) ? 8'hFF : 8'h00) : ~last_r;
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_mode  <= 2'h0;
            lvl_r   <= 4'h0;
            we_q    <= 1'b1;
            last_r  <= 8'h00;
            vaddr_r <= 3'h0;
        end else begin
            we_q   <= i_pins.we_n;
            last_r <= o_dq;
            if (!i_pins.ce_n && we_q && !i_pins.we_n) begin
                vaddr_r <= i_addr;
            end
            if (!i_pins.ce_n && !we_q && i_pins.we_n) begin
                case (i_pins.dq_out)
                    8'h20: begin
                        o_mode <= (o_mode == 2'h1) ? (i_supply_high ? 2'h2 : 2'h0) : 2'h1;
                        lvl_r  <= lvl_r + {3'h0, o_mode == 2'h1 && i_supply_high};
                    end
                    8'hA0: o_mode <= 2'h3;
                    default: o_mode <= 2'h0;
                endcase
            end
        end
    end
endmodule : flash_model

// File: verif/testbench.sv
// self-checking bench: erase sequencer against the flash model
// assumes design package, host and model compiled first
`timescale 1ns/1ns
module testbench;
    logic                       i_mclk    = 1'b0;
    logic                       i_reset   = 1'b1;
    logic                       i_start   = 1'b0;
    logic                       supply    = 1'b0;
    logic [2:0]                 weak_addr = 3'h0;
    logic [3:0]                 weak_need = 4'h1;
    erase_seq_pkg::status_t     status;
    erase_seq_pkg::flash_pins_t pins;
    logic [15:0]                pulses;
    logic [2:0]                 fail_addr;
    logic [2:0]                 addr;
    logic [7:0]                 dq;
    logic                       supply_req;
    logic [1:0]                 mode;
    int                         bad_count = 0;
    int                         checks    = 0;
    always #25 i_mclk = ~i_mclk;
    erase_seq_host #(.AW(3), .PULSE_CYC(50), .MAX_PULSES(3), .FINAL_CHECK(1'b1)) i_dut (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_start(i_start), .i_program_supply_high(supply),
        .o_status(status), .o_pulse_count(pulses), .o_fail_addr(fail_addr),
        .o_supply_request(supply_req), .o_addr(addr), .o_pins(pins), .i_dq(dq));
    flash_model i_flash (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(addr), .i_pins(pins),
        .i_supply_high(supply), .i_weak_addr(weak_addr), .i_weak_need(weak_need),
        .o_dq(dq), .o_mode(mode));
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("bad_count %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    // power cycle, start with supply low, then raise it and wait for done
    task automatic run(input logic [3:0] need, input logic [2:0] waddr);
        int n;
        i_reset   = 1'b1;
        supply    = 1'b0;
        weak_need = need;
        weak_addr = waddr;
        repeat (16) @(negedge i_mclk);
        chk("reset_pins", {12'h000, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 16'h000E);
        chk("reset_status", {12'h000, status}, 16'h0000);
        i_reset = 1'b0;
        @(negedge i_mclk);
        i_start = 1'b1;
        @(negedge i_mclk);
        i_start = 1'b0;
        chk("supply_req_on", {15'h0000, supply_req}, 16'h0001);
        repeat (60) @(negedge i_mclk);
        chk("no_write_low_supply", {12'h000, pins.ce_n, pins.we_n, mode}, 16'h000C);
        supply = 1'b1;
        n = 0;
        while (status.done !== 1'b1 && n < 20000) begin
            @(negedge i_mclk);
            n++;
        end
        if (n == 20000) begin
            bad_count++;
            end_sim();
        end
        chk("read_mode", {14'h0000, mode}, 16'h0000);
        chk("supply_req_off", {15'h0000, supply_req}, 16'h0000);
    endtask : run
    task automatic t_unprogrammed;
        run(4'h0, 3'h4);
        chk("fail_unprog", {15'h0000, status.fail}, 16'h0001);
        chk("pulses_unprog", pulses, 16'h0000);
        chk("addr_unprog", {13'h0000, fail_addr}, 16'h0004);
    endtask : t_unprogrammed
    task automatic t_clean;
        run(4'h1, 3'h0);
        chk("pulses_clean", pulses, 16'h0001);
        chk("fail_clean", {15'h0000, status.fail}, 16'h0000);
    endtask : t_clean
    task automatic t_slow_byte;
        run(4'h2, 3'h5);
        chk("pulses_slow", pulses, 16'h0002);
        chk("fail_slow", {15'h0000, status.fail}, 16'h0000);
        chk("cmp_slow", {15'h0000, status.compare_err}, 16'h0000);
    endtask : t_slow_byte
    task automatic t_stuck_byte;
        run(4'h5, 3'h2);
        chk("fail_stuck", {15'h0000, status.fail}, 16'h0001);
        chk("pulses_stuck", pulses, 16'h0003);
        chk("fail_addr", {13'h0000, fail_addr}, 16'h0002);
        chk("cmp_stuck", {15'h0000, status.compare_err}, 16'h0001);
    endtask : t_stuck_byte
    initial begin
        t_clean();
        t_slow_byte();
        t_stuck_byte();
        t_unprogrammed();
        end_sim();
    end
endmodule : testbench
bind erase_seq_host erase_seq_host_asserts #(.AW(AW), .PULSE_CYC(PULSE_CYC)) i_chk (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_program_supply_high(i_program_supply_high),
    .o_status(o_status), .o_pins(o_pins));
